// ==== core/cbm_pkg.sv ====
package cbm_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_CMD      = 8'h04;
    localparam logic [7:0] OFF_STATUS   = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
    localparam logic [7:0] OFF_SRQ_MASK = 8'h10;
    localparam logic [7:0] OFF_TXDATA   = 8'h14;
    localparam logic [7:0] OFF_STATE    = 8'h18;

    localparam logic [5:0] TALK_ONLY_ADDR = 6'h32;
    localparam logic [5:0] CTRL_RST       = 6'h00;
    localparam logic [3:0] MASK_RST       = 4'h0;
    localparam logic [1:0] PEAK_READS     = 2'h3;

    // Status bit positions
    localparam int NSTAT       = 4;
    localparam int ST_REFUSED  = 0;
    localparam int ST_TX_DONE  = 1;
    localparam int ST_PEAKS    = 2;
    localparam int ST_GATE     = 3;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [3:0] {
        CMD_SINGLE = 4'h0,
        CMD_AVG    = 4'h1,
        CMD_EXTARM = 4'h2,
        CMD_MATH   = 4'h3,
        CMD_AUTO   = 4'h4,
        CMD_ATTEN  = 4'h5,
        CMD_SENSE  = 4'h6,
        CMD_ANALOG = 4'h7,
        CMD_GATE   = 4'h8
    } cbm_cmd_t;

    typedef enum logic [2:0] {
        MD_FREQ = 3'b001,
        MD_PEAK = 3'b010,
        MD_GATE = 3'b100
    } cbm_mode_t;

    typedef struct packed {
        logic       single_cycle;
        logic       avg100;
        logic       external_arming_select;
        logic       math_bypass;
        logic       automatic_trigger_level;
        logic       tenfold_attenuator;
        logic       sensitivity_select;
        logic       analog_level_outputs;
        logic [7:0] gate_time;
    } cbm_set_t;

    localparam cbm_set_t SET_RST = cbm_set_t'(16'h0801);

    typedef struct packed {
        logic       peak_b;
        logic       second_channel_frequency_function;
        logic       gate;
        logic       read_levels;
        logic [7:0] value;
    } cbm_key_t;

    typedef struct packed {
        logic mta;
        logic mla;
        logic unt;
        logic unl;
        logic spe;
        logic spd;
        logic ppoll;
        logic rfd;
        logic dac;
    } cbm_bus_t;

    // Commands barred while peak-level mode runs
    function automatic logic cbm_locked(input cbm_cmd_t c, input logic a);
        case (c)
            CMD_AVG, CMD_SENSE, CMD_ANALOG:     cbm_locked = a;
            CMD_MATH, CMD_AUTO:                 cbm_locked = !a;
            CMD_EXTARM, CMD_ATTEN, CMD_GATE:    cbm_locked = 1'b1;
            default:                            cbm_locked = 1'b0;
        endcase
    endfunction

endpackage

// ==== core/cbm_settings.sv ====
`timescale 1ns/1ps
module cbm_settings import cbm_pkg::*; (
    input  wire logic      pclk,
    input  wire logic      presetn,
    input  wire cbm_key_t  key,
    input  wire logic      cmd_valid,
    input  wire cbm_cmd_t  cmd_code,
    input  wire logic [7:0] cmd_arg,
    output cbm_set_t       set_q,
    output cbm_mode_t      mode_q,
    output logic           gate_ind_q,
    output logic           show_q,
    output logic           refused_q,
    output logic           peaks_q,
    output logic           stored_q
);
    cbm_mode_t  mode_d;
    logic [1:0] reads_q;
    logic       enter_peak;

    // ----------------------------------------
    // Mode
    // ----------------------------------------
    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            MD_FREQ: begin
                if (key.peak_b) mode_d = MD_PEAK;
                else if (key.gate) mode_d = MD_GATE;
            end
            MD_PEAK: if (key.second_channel_frequency_function) mode_d = MD_FREQ;
            MD_GATE: if (key.gate) mode_d = MD_FREQ;
        endcase
    end

    assign enter_peak = (mode_q != MD_PEAK) && (mode_d == MD_PEAK);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q     <= MD_FREQ;
            gate_ind_q <= 1'b0;
        end else begin
            mode_q     <= mode_d;
            gate_ind_q <= (mode_d == MD_GATE);
        end
    end

    // ----------------------------------------
    // Peak level readout
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reads_q <= 2'h0;
            show_q  <= 1'b0;
            peaks_q <= 1'b0;
        end else begin
            peaks_q <= 1'b0;
            if (mode_q != MD_PEAK) begin
                reads_q <= 2'h0;
                show_q  <= 1'b0;
            end else if (key.read_levels && !show_q) begin
                reads_q <= reads_q + 2'h1;
                if (reads_q == PEAK_READS - 2'h1) begin
                    show_q  <= 1'b1;
                    peaks_q <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // Settings
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            set_q     <= SET_RST;
            refused_q <= 1'b0;
            stored_q  <= 1'b0;
        end else begin
            refused_q <= 1'b0;
            stored_q  <= 1'b0;
            if (enter_peak) begin
                set_q.single_cycle            <= 1'b0;
                set_q.avg100                  <= 1'b0;
                set_q.external_arming_select  <= 1'b0;
                set_q.math_bypass             <= 1'b1;
                set_q.automatic_trigger_level <= 1'b1;
                set_q.sensitivity_select      <= 1'b0;
                set_q.analog_level_outputs    <= 1'b0;
            end else if (mode_q == MD_GATE && key.gate) begin
                set_q.gate_time <= key.value;
                stored_q        <= 1'b1;
            end else if (cmd_valid) begin
                // Lockout keeps settings untouched, only flags the refusal
                if (mode_q == MD_PEAK && cbm_locked(cmd_code, cmd_arg[0])) begin
                    refused_q <= 1'b1;
                end else begin
                    case (cmd_code)
                        CMD_SINGLE: set_q.single_cycle            <= cmd_arg[0];
                        CMD_AVG:    set_q.avg100                  <= cmd_arg[0];
                        CMD_EXTARM: set_q.external_arming_select  <= cmd_arg[0];
                        CMD_MATH:   set_q.math_bypass             <= cmd_arg[0];
                        CMD_AUTO:   set_q.automatic_trigger_level <= cmd_arg[0];
                        CMD_ATTEN:  set_q.tenfold_attenuator      <= cmd_arg[0];
                        CMD_SENSE:  set_q.sensitivity_select      <= cmd_arg[0];
                        CMD_ANALOG: set_q.analog_level_outputs    <= cmd_arg[0];
                        CMD_GATE:   set_q.gate_time               <= cmd_arg;
                        default:    set_q <= set_q;
                    endcase
                end
            end
        end
    end

endmodule

// ==== core/cbm_link.sv ====
`timescale 1ns/1ps
module cbm_link import cbm_pkg::*; (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire cbm_bus_t   bus,
    input  wire logic       talk_only,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_byte,
    input  wire logic [7:0] stb,
    output logic            talk_ind_q,
    output logic            listen_ind_q,
    output logic [7:0]      dio_q,
    output logic            dav_q,
    output logic            tx_done_q,
    output logic            polled_q
);
    logic talk_q;
    logic spoll_q;
    logic src_poll_q;
    logic talk_d;
    logic listen_d;
    logic start;
    logic dav_d;

    // Addressing: talk and listen unaddress each other; parallel poll is ignored
    assign talk_d   = bus.mta | (talk_q & !bus.unt & !bus.mla);
    assign listen_d = bus.mla | (listen_ind_q & !bus.unl & !bus.mta);
    // Sending only once allowed to talk
    assign start = !dav_q && !tx_done_q && (talk_q || talk_only) && bus.rfd
                   && ((spoll_q && talk_q) || tx_valid);
    assign dav_d = start | (dav_q & !bus.dac);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            talk_q       <= 1'b0;
            talk_ind_q   <= 1'b0;
            listen_ind_q <= 1'b0;
            spoll_q      <= 1'b0;
        end else begin
            talk_q       <= talk_d;
            talk_ind_q   <= talk_d | talk_only | dav_d;
            listen_ind_q <= listen_d;
            if (bus.spe) spoll_q <= 1'b1;
            else if (bus.spd) spoll_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Source handshake
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dio_q      <= 8'h00;
            dav_q      <= 1'b0;
            src_poll_q <= 1'b0;
            tx_done_q  <= 1'b0;
            polled_q   <= 1'b0;
        end else begin
            tx_done_q <= 1'b0;
            polled_q  <= 1'b0;
            dav_q     <= dav_d;
            if (start) begin
                src_poll_q <= spoll_q && talk_q;
                dio_q      <= (spoll_q && talk_q) ? stb : tx_byte;
            end else if (dav_q && bus.dac) begin
                tx_done_q <= !src_poll_q;
                polled_q  <= src_poll_q;
            end
        end
    end

endmodule

// ==== core/cbm_top.sv ====
`timescale 1ns/1ps
module cbm_top import cbm_pkg::*; (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire cbm_key_t    key,
    input  wire cbm_bus_t    bus,
    output logic [7:0]       dio,
    output logic             dav,
    output logic             talk_indicator,
    output logic             listen_indicator,
    output logic             gate_indicator,
    output logic             show_peaks,
    output cbm_set_t         settings,
    output logic             srq,
    output logic             irq
);
    logic [5:0]       ctrl_q;
    logic [NSTAT-1:0] status_q;
    logic [NSTAT-1:0] irq_mask_q;
    logic [NSTAT-1:0] srq_mask_q;
    logic [NSTAT-1:0] st_set;
    logic [NSTAT-1:0] st_clr;
    logic [7:0]       tx_byte_q;
    logic             tx_pend_q;
    logic             cmd_valid_q;
    cbm_cmd_t         cmd_code_q;
    logic [7:0]       cmd_arg_q;
    logic             wr_en;
    logic             hit;
    logic [31:0]      rdata;
    logic             talk_only;
    logic [7:0]       stb;
    cbm_mode_t        mode;
    logic             refused;
    logic             peaks_ev;
    logic             stored;
    logic             tx_done;

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // One wait state: the answer comes on the second access cycle
    assign wr_en = psel && penable && pready && pwrite;

    always_comb begin
        hit   = 1'b1;
        rdata = 32'h0000_0000;
        case (paddr)
            OFF_CTRL:     rdata[5:0] = ctrl_q;
            OFF_CMD:      rdata[15:0] = settings;
            OFF_STATUS:   rdata[NSTAT-1:0] = status_q;
            OFF_IRQ_MASK: rdata[NSTAT-1:0] = irq_mask_q;
            OFF_SRQ_MASK: rdata[NSTAT-1:0] = srq_mask_q;
            OFF_TXDATA:   rdata[8:0] = {tx_pend_q, tx_byte_q};
            OFF_STATE:    rdata[7:0] = {listen_indicator, talk_indicator, gate_indicator,
                                        show_peaks, srq, mode};
            default:      hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !hit;
            if (psel && penable && !pready && !pwrite) prdata <= rdata;
        end
    end

    // ----------------------------------------
    // Configuration and commands
    // ----------------------------------------
    assign talk_only = (ctrl_q == TALK_ONLY_ADDR);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q     <= CTRL_RST;
            irq_mask_q <= MASK_RST;
            srq_mask_q <= MASK_RST;
        end else if (wr_en) begin
            if (paddr == OFF_CTRL) ctrl_q <= pwdata[5:0];
            if (paddr == OFF_IRQ_MASK) irq_mask_q <= pwdata[NSTAT-1:0];
            if (paddr == OFF_SRQ_MASK) srq_mask_q <= pwdata[NSTAT-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_valid_q <= 1'b0;
            cmd_code_q  <= CMD_SINGLE;
            cmd_arg_q   <= 8'h00;
        end else begin
            cmd_valid_q <= wr_en && (paddr == OFF_CMD);
            if (wr_en && paddr == OFF_CMD) begin
                cmd_code_q <= cbm_cmd_t'(pwdata[11:8]);
                cmd_arg_q  <= pwdata[7:0];
            end
        end
    end

    // A byte written while one is still pending is dropped, not queued
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_pend_q <= 1'b0;
            tx_byte_q <= 8'h00;
        end else if (tx_done) begin
            tx_pend_q <= 1'b0;
        end else if (wr_en && paddr == OFF_TXDATA && !tx_pend_q) begin
            tx_pend_q <= 1'b1;
            tx_byte_q <= pwdata[7:0];
        end
    end

    // ----------------------------------------
    // Status, interrupt and service request
    // ----------------------------------------
    assign st_set = {stored, peaks_ev, tx_done, refused};
    assign st_clr = (wr_en && paddr == OFF_STATUS) ? pwdata[NSTAT-1:0] : '0;
    assign stb    = {1'b0, srq, 2'h0, status_q};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= '0;
            irq      <= 1'b0;
            srq      <= 1'b0;
        end else begin
            status_q <= (status_q & ~st_clr) | st_set;
            irq      <= |(status_q & irq_mask_q);
            srq      <= |(status_q & srq_mask_q);
        end
    end

    // ----------------------------------------
    // Sub blocks
    // ----------------------------------------
    cbm_settings u_set (
        .pclk       (pclk),
        .presetn    (presetn),
        .key        (key),
        .cmd_valid  (cmd_valid_q),
        .cmd_code   (cmd_code_q),
        .cmd_arg    (cmd_arg_q),
        .set_q      (settings),
        .mode_q     (mode),
        .gate_ind_q (gate_indicator),
        .show_q     (show_peaks),
        .refused_q  (refused),
        .peaks_q    (peaks_ev),
        .stored_q   (stored)
    );

    cbm_link u_link (
        .pclk         (pclk),
        .presetn      (presetn),
        .bus          (bus),
        .talk_only    (talk_only),
        .tx_valid     (tx_pend_q),
        .tx_byte      (tx_byte_q),
        .stb          (stb),
        .talk_ind_q   (talk_indicator),
        .listen_ind_q (listen_indicator),
        .dio_q        (dio),
        .dav_q        (dav),
        .tx_done_q    (tx_done),
        .polled_q     ()
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_peak_preset: assert property (
        mode != MD_PEAK && key.peak_b && mode == MD_FREQ |=> mode == MD_PEAK
        && settings.math_bypass && settings.automatic_trigger_level
        && !settings.avg100 && !settings.single_cycle && !settings.sensitivity_select)
        else $error("peak preset not applied");

    a_lockout_hold: assert property (
        cmd_valid_q && mode == MD_PEAK && !key.second_channel_frequency_function
        && cbm_locked(cmd_code_q, cmd_arg_q[0]) |=> $stable(settings) && refused)
        else $error("locked command changed settings");

    a_single_open: assert property (
        cmd_valid_q && cmd_code_q == CMD_SINGLE && mode == MD_PEAK
        |=> settings.single_cycle == $past(cmd_arg_q[0]) && !refused)
        else $error("single cycle refused in peak mode");

    a_three_reads: assert property (
        $rose(show_peaks) |-> $past(mode) == MD_PEAK && $past(key.read_levels))
        else $error("peaks shown without third read");

    a_gate_store: assert property (
        mode == MD_GATE && key.gate |=> mode == MD_FREQ && !gate_indicator
        && settings.gate_time == $past(key.value))
        else $error("gate value not stored");

    a_talk_gate: assert property (
        $rose(dav) |-> $past(talk_indicator) || $past(talk_only))
        else $error("data sent while not talker");

    a_talk_lamp: assert property (
        dav |-> talk_indicator)
        else $error("talk indicator dark while talking");

    a_listen_lamp: assert property (
        bus.mla |=> listen_indicator ##1 (listen_indicator || $past(bus.unl) || $past(bus.mta)))
        else $error("listen indicator not lit");

    a_srq_level: assert property (
        |(status_q & srq_mask_q) |=> srq)
        else $error("service request missing");

    a_w1c_set_wins: assert property (
        st_set[ST_REFUSED] && st_clr[ST_REFUSED] |=> status_q[ST_REFUSED])
        else $error("status event lost on clear");

    a_w1c_gate_wins: assert property (
        st_set[ST_GATE] && st_clr[ST_GATE] |=> status_q[ST_GATE])
        else $error("gate event lost on clear");

    // A stalled listener must see the same byte until it accepts
    a_dav_hold: assert property (
        dav && !bus.dac |=> dav && $stable(dio))
        else $error("data valid dropped before acceptance");

    a_irq_level: assert property (
        |(status_q & irq_mask_q) |=> irq)
        else $error("interrupt missing");

    c_peak_shown:  cover property (key.peak_b ##[1:40] show_peaks);
    c_gate_stored: cover property (mode == MD_GATE ##[1:40] stored);
    c_talk_only:   cover property (talk_only && $rose(dav));
    c_refused:     cover property (refused);
    c_set_wins:    cover property (st_set[ST_GATE] && st_clr[ST_GATE]);

endmodule

// ==== verification/cbm_bus_model.sv ====
`timescale 1ns/1ps
module cbm_bus_model import cbm_pkg::*; (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire cbm_bus_t   req,
    input  wire logic       slow,
    input  wire logic       dav,
    input  wire logic [7:0] dio,
    output cbm_bus_t        bus,
    output logic [7:0]      got_q,
    output logic [7:0]      cnt_q
);
    // ----------------------------------------
    // Controller and listen-only acceptor
    // ----------------------------------------
    logic [1:0] wait_q;
    logic       dac_q;

    // Addressing commands are one-cycle pulses; nothing is ever sent to the device
    always_comb begin
        bus     = req;
        bus.rfd = 1'b1;
        bus.dac = dac_q;
    end

    // A slow listener stalls three cycles before it accepts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q <= 2'h0;
            dac_q  <= 1'b0;
            got_q  <= 8'h00;
            cnt_q  <= 8'h00;
        end else if (dac_q) begin
            if (!dav) begin
                dac_q <= 1'b0;
            end
        end else if (dav) begin
            if (slow && wait_q != 2'h3) begin
                wait_q <= wait_q + 2'h1;
            end else begin
                wait_q <= 2'h0;
                dac_q  <= 1'b1;
                got_q  <= dio;
                cnt_q  <= cnt_q + 8'h01;
            end
        end
    end
endmodule

// ==== verification/counter_bus_mode_control_tb.sv ====
`timescale 1ns/1ps
module counter_bus_mode_control_tb import cbm_pkg::*; ();
    // ----------------------------------------
    // Bench signals
    // ----------------------------------------
    localparam logic [8:0] MTA = 9'h100, MLA = 9'h080, UNT = 9'h040, UNL = 9'h020;
    localparam logic [8:0] SPE = 9'h010, SPD = 9'h008, PPL = 9'h004;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slverr;
    logic        dav, talk_ind, listen_ind, gate_ind, show, srq, irq, slow;
    logic [7:0]  paddr, dio, got, cnt, c0;
    logic [31:0] pwdata, prdata, rd;
    cbm_key_t    key;
    cbm_bus_t    bus, req;
    cbm_set_t    settings;
    int          err_count, tests_run, cyc;

    cbm_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .key(key), .bus(bus), .dio(dio), .dav(dav),
        .talk_indicator(talk_ind), .listen_indicator(listen_ind), .gate_indicator(gate_ind),
        .show_peaks(show), .settings(settings), .srq(srq), .irq(irq));
    cbm_bus_model ctl_u (.pclk(pclk), .presetn(presetn), .req(req), .slow(slow),
        .dav(dav), .dio(dio), .bus(bus), .got_q(got), .cnt_q(cnt));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Run is a few hundred cycles; the ceiling only catches a hang
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            err_count++;
            tally_and_finish;
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        slverr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdr(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic cmd(input logic [11:0] v);
        wr(OFF_CMD, {20'h0, v});
        tick(2);
    endtask

    task automatic press(input logic [11:0] v);
        key <= cbm_key_t'(v);
        @(posedge pclk);
        key <= '0;
        tick(1);
    endtask

    task automatic bcmd(input logic [8:0] v);
        req <= cbm_bus_t'(v);
        @(posedge pclk);
        req <= '0;
        tick(1);
    endtask

    task automatic await_byte(input logic [7:0] old);
        int n;
        n = 0;
        while (cnt === old && n < 60) begin
            @(posedge pclk);
            n++;
        end
        chk("byte arrived", 32'h1, {31'h0, cnt !== old});
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        chk("reset settings", 32'h0801, {16'h0, settings});
        rdr(OFF_STATE);
        chk("reset state", 32'h1, rd);
        rdr(8'h1c);
        chk("unmapped", 32'h1, {31'h0, slverr});
    endtask

    task automatic t_peak;
        cmd(12'h101);
        cmd(12'h001);
        cmd(12'h701);
        cmd(12'h201);
        cmd(12'h601);
        chk("freq cmds", 32'heb01, {16'h0, settings});
        press(12'h800);
        chk("preset", 32'h1801, {16'h0, settings});
        rdr(OFF_STATE);
        chk("peak mode", 32'h2, rd);
    endtask

    task automatic t_lock;
        logic [11:0] tbl [8];
        tbl = '{12'h101, 12'h201, 12'h300, 12'h400, 12'h501, 12'h601, 12'h701, 12'h805};
        foreach (tbl[i]) begin
            cmd(tbl[i]);
            chk("locked settings", 32'h1801, {16'h0, settings});
            rdr(OFF_STATUS);
            chk("refused", 32'h1, rd);
            wr(OFF_STATUS, 32'h1);
        end
        cmd(12'h001);
        chk("single", 32'h9801, {16'h0, settings});
        rdr(OFF_STATUS);
        chk("accepted", 32'h0, rd);
    endtask

    task automatic t_levels;
        press(12'h100);
        press(12'h100);
        chk("two reads", 32'h0, {31'h0, show});
        press(12'h100);
        chk("three reads", 32'h1, {31'h0, show});
        rdr(OFF_STATUS);
        chk("peaks event", 32'h4, rd);
    endtask

    task automatic t_gate;
        press(12'h400);
        press(12'h211);
        rdr(OFF_STATE);
        chk("gate entry", 32'h24, {26'h0, gate_ind, rd[4:0]});
        // Store lands in the same cycle as a clear of its own status bit
        fork
            wr(OFF_STATUS, 32'h8);
            begin
                tick(1);
                press(12'h22a);
            end
        join
        chk("stored", 32'h982a, {16'h0, settings});
        rdr(OFF_STATE);
        chk("freq again", 32'h1, rd);
        rdr(OFF_STATUS);
        chk("gate event", 32'hc, rd);
        wr(OFF_STATUS, 32'h4);
    endtask

    task automatic t_irq;
        chk("unmasked", 32'h0, {30'h0, srq, irq});
        wr(OFF_IRQ_MASK, 32'h8);
        wr(OFF_SRQ_MASK, 32'h8);
        tick(1);
        chk("raised", 32'h3, {30'h0, srq, irq});
        wr(OFF_IRQ_MASK, 32'h0);
        tick(1);
        chk("irq masked", 32'h2, {30'h0, srq, irq});
    endtask

    task automatic t_poll;
        bcmd(MTA);
        c0 = cnt;
        bcmd(SPE);
        await_byte(c0);
        chk("poll byte", 32'h48, {24'h0, got});
        bcmd(SPD);
        bcmd(UNT);
        tick(4);
        chk("untalk", 32'h0, {31'h0, talk_ind});
        wr(OFF_STATUS, 32'hf);
        tick(1);
        chk("srq cleared", 32'h0, {30'h0, srq, irq});
    endtask

    task automatic t_talk;
        slow <= 1'b1;
        wr(OFF_TXDATA, 32'h5a);
        tick(10);
        chk("unaddressed", 32'h0, {30'h0, talk_ind, dav});
        c0 = cnt;
        bcmd(MTA);
        chk("talk ind", 32'h1, {31'h0, talk_ind});
        await_byte(c0);
        chk("sent", 32'h5a, {24'h0, got});
        tick(4);
        rdr(OFF_STATUS);
        chk("tx done", 32'h2, rd);
        bcmd(MLA);
        chk("listen", 32'h2, {30'h0, listen_ind, talk_ind});
        bcmd(MTA);
        chk("talk clears", 32'h1, {30'h0, listen_ind, talk_ind});
        bcmd(UNT);
        bcmd(PPL);
        tick(10);
        chk("no ppoll", 32'h0, {29'h0, listen_ind, talk_ind, dav});
        slow <= 1'b0;
        wr(OFF_CTRL, 32'h32);
        c0 = cnt;
        wr(OFF_TXDATA, 32'hc3);
        await_byte(c0);
        chk("talk only", 32'h1c3, {23'h0, talk_ind, got});
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        key = '0;
        req = '0;
        slow = 1'b0;
        err_count = 0;
        tests_run = 0;
        cyc = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_peak;
        t_lock;
        t_levels;
        t_gate;
        t_irq;
        t_poll;
        t_talk;
        tally_and_finish;
    end
endmodule
